// File: hw/spindle_pkg.sv
package spindle_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int CHOP_OFF_NS = 10000;
  localparam int CHOP_OFF_CYCLES = (CHOP_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERIOD_W = 20;
  localparam int DLY_SHIFT = 5;
  localparam int MASK_SHORT_SHIFT = 3;
  localparam int MASK_LONG_SHIFT = 2;
  localparam int FB_DIV = 3;
  localparam int STEPS_PER_ETURN = 6;
  localparam int POLE_DIV_LO = 4;
  localparam int POLE_DIV_HI = 6;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TIMING = 4'h1;
  localparam logic [3:0] REG_SENSE = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [7:0] CTRL_RST = 8'h02;
  localparam logic [7:0] TIMING_RST = 8'hf0;
  localparam logic [7:0] SENSE_RST = 8'h00;
  localparam int CTRL_FBSRC = 7;
  localparam int CTRL_CYCSEL = 5;
  localparam int CTRL_INTBEMF = 1;
  localparam int CTRL_STEP = 0;
  localparam int TIM_DLY_LSB = 4;
  localparam int TIM_POLE = 3;
  localparam int TIM_MASK = 0;
  localparam int SNS_SPINEN = 7;
  localparam int SNS_LOOPRATE = 4;
  localparam int SNS_INDUCTIVE_SENSE_SELECT = 3;
  localparam int SNS_PWM = 0;

  // ****************************************
  // drive table, one 3-bit entry per phase (c,b,a)
  // ****************************************
  localparam logic [17:0] HI_TAB = {3'b100, 3'b100, 3'b010, 3'b010, 3'b001, 3'b001};
  localparam logic [17:0] LO_TAB = {3'b010, 3'b001, 3'b001, 3'b100, 3'b100, 3'b010};
  localparam logic [2:0] LAST_PHASE = 3'h5;

  typedef enum logic [1:0] {ST_WATCH, ST_DELAY, ST_MASK} seq_state_e;
endpackage

// File: hw/commutation_if.sv
`timescale 1ns/1ps
`default_nettype none
interface commutation_if;
  import spindle_pkg::*;
  logic zc;
  logic comm;
  logic ext_mode;
  logic mask_long;
  logic pole_sel;
  logic [3:0] delay_sel;
  logic [PERIOD_W-1:0] delay_cnt;
  logic [PERIOD_W-1:0] mask_cnt;

  modport seq (output zc, comm, ext_mode, mask_long, pole_sel, delay_sel,
    input delay_cnt, mask_cnt);
  modport tmr (input zc, mask_long, delay_sel, output delay_cnt, mask_cnt);
  modport fb (input zc, comm, ext_mode, pole_sel);
endinterface
`default_nettype wire

// File: hw/interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module interval_timer
  import spindle_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  commutation_if.tmr cif
);
  logic [PERIOD_W-1:0] run_q;
  logic [PERIOD_W-1:0] period_q;
  logic [PERIOD_W+4:0] prod;

  // saturate so a stalled motor cannot wrap to a tiny period
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_q <= '0;
      period_q <= '1;
    end else if (cif.zc) begin
      period_q <= run_q;
      run_q <= '0;
    end else if (run_q != '1) begin
      run_q <= run_q + 1'b1;
    end
  end

  // half the interval is 30 degrees; one step is a 32nd
  assign prod = period_q * ({1'b0, cif.delay_sel} + 5'h01);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cif.delay_cnt <= '0;
      cif.mask_cnt <= '0;
    end else begin
      cif.delay_cnt <= prod[PERIOD_W+4:DLY_SHIFT];
      cif.mask_cnt <= cif.mask_long ? (period_q >> MASK_LONG_SHIFT)
                                    : (period_q >> MASK_SHORT_SHIFT);
    end
  end
endmodule // interval_timer
`default_nettype wire

// File: hw/feedback_gen.sv
`timescale 1ns/1ps
`default_nettype none
module feedback_gen
  import spindle_pkg::*;
#(
  parameter int CHOP_CYCLES = CHOP_OFF_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  commutation_if.fb cif,
  input wire logic spin_en,
  input wire logic inductive_sense_select,
  input wire logic loop_rate,
  input wire logic cyc_sel,
  input wire logic pwm_mode,
  input wire logic fbsrc,
  input wire logic thr_s,
  input wire logic index_s,
  output logic commutation_feedback_output_q,
  output logic speed_fb_q
);
  logic [2:0] ecnt_q;
  logic [2:0] mcnt_q;
  logic [2:0] div;
  logic [1:0] f3_q;
  logic commutation_feedback_output_prev_q;
  logic thr_hit_q;
  logic [15:0] chop_q;
  logic eturn;
  logic mturn;
  logic toggle;

  assign div = cyc_sel ? 3'd1 : (cif.pole_sel ? 3'(POLE_DIV_HI) : 3'(POLE_DIV_LO));
  assign eturn = cif.zc && (ecnt_q == 3'(STEPS_PER_ETURN - 1));
  assign mturn = eturn && (mcnt_q == div - 3'd1);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ecnt_q <= '0;
      mcnt_q <= '0;
    end else if (cif.zc) begin
      ecnt_q <= eturn ? 3'd0 : ecnt_q + 3'd1;
      if (eturn) mcnt_q <= mturn ? 3'd0 : mcnt_q + 3'd1;
    end
  end

  // external processing shows every crossing to the host unless inductive sense is selected
  always_comb begin
    if (cif.ext_mode || !loop_rate) toggle = cif.zc;
    else if (cyc_sel) toggle = eturn;
    else toggle = mturn;
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !spin_en) thr_hit_q <= 1'b0;
    else if (thr_s) thr_hit_q <= 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      commutation_feedback_output_q <= 1'b0;
      chop_q <= '0;
    end else if (inductive_sense_select) begin
      if (!spin_en || !thr_hit_q) begin
        commutation_feedback_output_q <= 1'b0;
        chop_q <= '0;
      end else if (!pwm_mode) begin
        commutation_feedback_output_q <= 1'b1;
      end else if (chop_q == 16'(CHOP_CYCLES - 1)) begin
        commutation_feedback_output_q <= !commutation_feedback_output_q;
        chop_q <= '0;
      end else begin
        chop_q <= chop_q + 16'h0001;
      end
    end else if (toggle) begin
      commutation_feedback_output_q <= !commutation_feedback_output_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      commutation_feedback_output_prev_q <= 1'b0;
      f3_q <= '0;
      speed_fb_q <= 1'b0;
    end else begin
      commutation_feedback_output_prev_q <= commutation_feedback_output_q;
      if (fbsrc) begin
        speed_fb_q <= index_s;
      end else if (commutation_feedback_output_q != commutation_feedback_output_prev_q) begin
        f3_q <= (f3_q == 2'(FB_DIV - 1)) ? 2'd0 : f3_q + 2'd1;
        if (f3_q == 2'(FB_DIV - 1)) speed_fb_q <= !speed_fb_q;
      end
    end
  end
endmodule // feedback_gen
`default_nettype wire

// File: hw/spindle_commutation_sequencer.sv
// Summary of operation
// - source select one: feedback from index pin
// - source select zero: feedback is output divided by three
// - each phase: one high, one low, one floating
// - phases advance through the six-step rotation
// - crossings blanked from detection onward
// - mask extends 12.5% or 25% of period
// - after blanking, crossing starts delayed commutation
// - delay field: 1.875 to 30 degrees
// - default output toggles every crossing
// - loop rate set, internal processing: toggle per mechanical turn
// - loop rate and cycle set: electrical turn
// - turn divider is one, four or six
// - linear inductive sense: high at threshold
// - pwm inductive sense: chop at off-time
// - power-good fall: tristate and start retract
// - power down: low side follows commutation
// - isolation switch follows power-good level
// - internal processing off: host paces commutation
// - step bit high masks crossings
`timescale 1ns/1ps
`default_nettype none
module spindle_commutation_sequencer
  import spindle_pkg::*;
#(
  parameter int CHOP_CYCLES = CHOP_OFF_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic zc_cmp,
  input wire logic index_in,
  input wire logic por_in,
  input wire logic thresh_in,
  output logic [2:0] hi_drive,
  output logic [2:0] lo_drive,
  output logic [2:0] phase_oe,
  output logic isofet_on,
  output logic retract_start,
  output logic commutation_feedback_output,
  output logic speed_fb
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic zc_s;
  logic index_s;
  logic por_s;
  logic thr_s;
  logic zc_prev_q;
  logic por_prev_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {thresh_in, por_in, index_in, zc_cmp};
      sync2_q <= sync1_q;
    end
  end

  assign {thr_s, por_s, index_s, zc_s} = sync2_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      zc_prev_q <= 1'b0;
      por_prev_q <= 1'b0;
    end else begin
      zc_prev_q <= zc_s;
      por_prev_q <= por_s;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] timing_q;
  logic [7:0] sense_q;
  logic step_prev_q;
  logic step_rise;
  logic ext_mode;
  seq_state_e st_q;
  logic [2:0] phase_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      timing_q <= TIMING_RST;
      sense_q <= SENSE_RST;
    end else if (wr_stb) begin
      case (addr)
        REG_CTRL: ctrl_q <= wdata;
        REG_TIMING: timing_q <= wdata;
        REG_SENSE: sense_q <= wdata;
        default: ;
      endcase
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd_stb) begin
      case (addr)
        REG_CTRL: rdata <= ctrl_q;
        REG_TIMING: rdata <= timing_q;
        REG_SENSE: rdata <= sense_q;
        REG_STATUS: rdata <= {por_s, zc_s, st_q, 1'b0, phase_q};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) step_prev_q <= 1'b0;
    else step_prev_q <= ctrl_q[CTRL_STEP];
  end

  // host writes a rising step bit once its own delay has run out
  assign step_rise = ctrl_q[CTRL_STEP] && !step_prev_q;
  assign ext_mode = !ctrl_q[CTRL_INTBEMF];

  // ****************************************
  // interval timing and feedback
  // ****************************************
  commutation_if cif ();
  logic zc_edge;
  logic zc_take;
  logic blanking;
  logic comm;

  assign zc_edge = zc_s != zc_prev_q;
  assign cif.zc = zc_take;
  assign cif.comm = comm;
  assign cif.ext_mode = ext_mode;
  assign cif.mask_long = timing_q[TIM_MASK];
  assign cif.pole_sel = timing_q[TIM_POLE];
  assign cif.delay_sel = timing_q[TIM_DLY_LSB+3:TIM_DLY_LSB];

  interval_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .cif(cif)
  );

  feedback_gen #(
    .CHOP_CYCLES(CHOP_CYCLES)
  ) u_fb (
    .ref_clk(ref_clk),
    .rst(rst),
    .cif(cif),
    .spin_en(sense_q[SNS_SPINEN]),
    .inductive_sense_select(sense_q[SNS_INDUCTIVE_SENSE_SELECT]),
    .loop_rate(sense_q[SNS_LOOPRATE]),
    .cyc_sel(ctrl_q[CTRL_CYCSEL]),
    .pwm_mode(sense_q[SNS_PWM]),
    .fbsrc(ctrl_q[CTRL_FBSRC]),
    .thr_s(thr_s),
    .index_s(index_s),
    .commutation_feedback_output_q(commutation_feedback_output),
    .speed_fb_q(speed_fb)
  );

  // ****************************************
  // sequencer
  // ****************************************
  logic [PERIOD_W-1:0] cnt_q;

  // blank from the detected crossing through the post-commutation mask
  assign blanking = (st_q != ST_WATCH) || ctrl_q[CTRL_STEP];
  assign zc_take = zc_edge && !blanking;

  always_comb begin
    if (ext_mode) comm = step_rise;
    else comm = (st_q == ST_DELAY) && (cnt_q <= {{(PERIOD_W-1){1'b0}}, 1'b1});
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_WATCH;
      cnt_q <= '0;
    end else if (comm) begin
      st_q <= ST_MASK;
      cnt_q <= cif.mask_cnt;
    end else begin
      case (st_q)
        ST_WATCH: begin
          if (zc_take) begin
            st_q <= ST_DELAY;
            cnt_q <= cif.delay_cnt;
          end
        end
        ST_DELAY: begin
          if (!ext_mode) cnt_q <= cnt_q - 1'b1;
        end
        ST_MASK: begin
          if (cnt_q <= {{(PERIOD_W-1){1'b0}}, 1'b1}) st_q <= ST_WATCH;
          else cnt_q <= cnt_q - 1'b1;
        end
        default: st_q <= ST_WATCH;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) phase_q <= '0;
    else if (comm) phase_q <= (phase_q == LAST_PHASE) ? 3'h0 : phase_q + 3'h1;
  end

  // ****************************************
  // bridge drive and power-fail
  // ****************************************
  logic drive_ok;
  logic [2:0] hi_pat;
  logic [2:0] lo_pat;

  assign drive_ok = por_s && sense_q[SNS_SPINEN];
  assign hi_pat = HI_TAB[3*phase_q +: 3];
  assign lo_pat = LO_TAB[3*phase_q +: 3];

  // rectification keeps only the low side switching so bemf feeds the supply
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hi_drive <= '0;
      lo_drive <= '0;
      phase_oe <= '0;
    end else if (drive_ok) begin
      hi_drive <= hi_pat;
      lo_drive <= lo_pat;
      phase_oe <= hi_pat | lo_pat;
    end else if (!por_s) begin
      hi_drive <= '0;
      lo_drive <= lo_pat;
      phase_oe <= '0;
    end else begin
      hi_drive <= '0;
      lo_drive <= '0;
      phase_oe <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      isofet_on <= 1'b0;
      retract_start <= 1'b0;
    end else begin
      isofet_on <= por_s;
      retract_start <= por_prev_q && !por_s;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_power_fail_off:
    assert property (@(posedge ref_clk) disable iff (rst)
      $fell(por_s) |=> retract_start && !isofet_on && (phase_oe == 3'b000))
    else $error("power fail did not tristate and retract");

  a_isofet_on:
    assert property (@(posedge ref_clk) disable iff (rst)
      $rose(por_s) |=> isofet_on [*2])
    else $error("isolation switch not on with power good");

  a_blank_rejects:
    assert property (@(posedge ref_clk) disable iff (rst)
      (ctrl_q[CTRL_STEP] || st_q == ST_MASK || st_q == ST_DELAY) |-> !zc_take)
    else $error("crossing accepted while blanked");

  a_phase_advance:
    assert property (@(posedge ref_clk) disable iff (rst)
      comm |=> phase_q == (($past(phase_q) == LAST_PHASE) ? 3'h0 : $past(phase_q) + 3'h1))
    else $error("phase did not advance by one");

  a_drive_pattern:
    assert property (@(posedge ref_clk) disable iff (rst)
      (phase_oe != 3'b000) |-> $onehot(hi_drive) && $onehot(lo_drive)
        && ((hi_drive & lo_drive) == 3'b000) && $onehot(~phase_oe))
    else $error("drive pattern not one high one low one floating");

  a_mask_follows:
    assert property (@(posedge ref_clk) disable iff (rst)
      comm |=> (st_q == ST_MASK) && (cnt_q == $past(cif.mask_cnt)))
    else $error("mask not loaded at commutation");

  a_delay_load:
    assert property (@(posedge ref_clk) disable iff (rst)
      (zc_take && !comm) |=> (st_q == ST_DELAY) && (cnt_q == $past(cif.delay_cnt)))
    else $error("delay not started on crossing");

  a_host_paced:
    assert property (@(posedge ref_clk) disable iff (rst)
      ext_mode && (st_q == ST_DELAY) && !step_rise |=> $stable(phase_q))
    else $error("internal commutation in external mode");

  a_rectify_low:
    assert property (@(posedge ref_clk) disable iff (rst)
      !por_s && !$rose(por_s) |=> (hi_drive == 3'b000) && (lo_drive == $past(lo_pat)))
    else $error("low side not following commutation in power down");
endmodule // spindle_commutation_sequencer
`default_nettype wire

// File: tb/motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module motor_model #(
  parameter int GAP = 8
)
(
  input wire logic ref_clk,
  input wire logic [2:0] hi_drive,
  input wire logic [2:0] lo_drive,
  output logic zc_cmp
);
  logic [5:0] last_q = 6'h00;
  int cnt_q = 0;
  initial zc_cmp = 1'b0;
  // a new drive step makes the floating coil cross GAP cycles later;
  // no high side driven means no torque, so no crossing is produced
  always @(posedge ref_clk) begin
    last_q <= {hi_drive, lo_drive};
    if ({hi_drive, lo_drive} != last_q && hi_drive != 3'h0) cnt_q <= GAP;
    else if (cnt_q > 0) cnt_q <= cnt_q - 1;
    if (cnt_q == 1) zc_cmp <= ~zc_cmp;
  end
endmodule // motor_model
`default_nettype wire

// File: tb/spindle_commutation_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spindle_commutation_sequencer_tb;
  import spindle_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic zc_cmp;
  logic index_in = 1'b0;
  logic por_in = 1'b1;
  logic thresh_in = 1'b0;
  logic [2:0] hi_drive;
  logic [2:0] lo_drive;
  logic [2:0] phase_oe;
  logic isofet_on;
  logic retract_start;
  logic commutation_feedback_output;
  logic speed_fb;
  int bad_count = 0;
  int n_compared = 0;
  logic [7:0] v;

  always #10 ref_clk = ~ref_clk;

  spindle_commutation_sequencer #(.CHOP_CYCLES(4)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .zc_cmp(zc_cmp), .index_in(index_in), .por_in(por_in), .thresh_in(thresh_in),
    .hi_drive(hi_drive), .lo_drive(lo_drive), .phase_oe(phase_oe), .isofet_on(isofet_on),
    .retract_start(retract_start), .commutation_feedback_output(commutation_feedback_output), .speed_fb(speed_fb));

  motor_model #(.GAP(8)) u_motor (.ref_clk(ref_clk), .hi_drive(hi_drive),
    .lo_drive(lo_drive), .zc_cmp(zc_cmp));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk_phase(input int p);
    check({5'h0, hi_drive}, {5'h0, HI_TAB[3*p+:3]});
    check({5'h0, lo_drive}, {5'h0, LO_TAB[3*p+:3]});
    check({5'h0, phase_oe}, {5'h0, HI_TAB[3*p+:3] | LO_TAB[3*p+:3]});
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd(REG_CTRL, v);
    check(v, CTRL_RST);
    rd(REG_TIMING, v);
    check(v, TIMING_RST);
    rd(REG_SENSE, v);
    check(v, SENSE_RST);
    rd(4'h9, v);
    check(v, 8'h00);
    check({7'h0, isofet_on}, 8'h01);
    $display("test regs done");
  endtask

  // host paces the steps; each crossing after a host step lands while step is high
  task automatic t_steps();
    wr(REG_CTRL, 8'h00);
    wr(REG_SENSE, 8'h80);
    cyc(20);
    chk_phase(0);
    check({7'h0, commutation_feedback_output}, 8'h01);
    for (int k = 1; k <= 7; k++) begin
      wr(REG_CTRL, 8'h01);
      cyc(14);
      chk_phase(k % 6);
      check({7'h0, commutation_feedback_output}, 8'h01);
      wr(REG_CTRL, 8'h00);
    end
    $display("test steps done");
  endtask

  task automatic t_index();
    wr(REG_CTRL, 8'h80);
    @(posedge ref_clk);
    index_in <= 1'b1;
    cyc(5);
    check({7'h0, speed_fb}, 8'h01);
    index_in <= 1'b0;
    cyc(5);
    check({7'h0, speed_fb}, 8'h00);
    $display("test index done");
  endtask

  task automatic t_sense();
    int fe;
    int se;
    logic pf;
    logic ps;
    wr(REG_CTRL, 8'h02);
    wr(REG_SENSE, 8'h88);
    cyc(5);
    check({7'h0, commutation_feedback_output}, 8'h00);
    thresh_in <= 1'b1;
    cyc(6);
    check({7'h0, commutation_feedback_output}, 8'h01);
    wr(REG_SENSE, 8'h08);
    cyc(3);
    check({7'h0, commutation_feedback_output}, 8'h00);
    wr(REG_SENSE, 8'h89);
    cyc(8);
    fe = 0;
    se = 0;
    pf = commutation_feedback_output;
    ps = speed_fb;
    // 120 cycles at a 4-cycle half period is 30 edges, give or take one
    repeat (120) begin
      cyc(1);
      if (commutation_feedback_output !== pf) fe++;
      if (speed_fb !== ps) se++;
      pf = commutation_feedback_output;
      ps = speed_fb;
    end
    check({7'h0, fe >= 29 && fe <= 31}, 8'h01);
    check({7'h0, se >= 9 && se <= 11}, 8'h01);
    wr(REG_SENSE, 8'h09);
    cyc(3);
    check({7'h0, commutation_feedback_output}, 8'h00);
    // back to host pacing so the phase stays put for the power-down test
    wr(REG_CTRL, 8'h00);
    wr(REG_SENSE, 8'h80);
    $display("test sense done");
  endtask

  // internal commutation in the sense test leaves the phase unknown; read it back
  task automatic t_powerdown();
    int pulses;
    pulses = 0;
    cyc(4);
    rd(REG_STATUS, v);
    check({7'h0, v[7]}, 8'h01);
    cyc(2);
    chk_phase(int'(v[2:0]));
    por_in <= 1'b0;
    repeat (10) begin
      cyc(1);
      if (retract_start === 1'b1) pulses++;
    end
    check(pulses[7:0], 8'h01);
    check({7'h0, isofet_on}, 8'h00);
    check({2'h0, phase_oe, hi_drive}, 8'h00);
    check({5'h0, lo_drive}, {5'h0, LO_TAB[3*v[2:0]+:3]});
    $display("test powerdown done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    cyc(20);
    check({phase_oe, hi_drive, isofet_on, commutation_feedback_output}, 8'h00);
    rst <= 1'b0;
    cyc(4);
    t_regs();
    t_steps();
    t_index();
    t_sense();
    t_powerdown();
    test_done();
  end

  // whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end
endmodule // spindle_commutation_sequencer_tb
`default_nettype wire
